// [design/rgci_pkg.sv]
// Package of constants and types for the remote gage command input block.
package rgci_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned QUAL_TIME_MS = 50;
  // Least time; the count is exact, with nothing added for rounding.
  localparam int unsigned QUAL_CYCLES =
    (QUAL_TIME_MS * (CLK_FREQ_HZ / 1000) + 0) ;
  localparam int unsigned QUAL_CNT_W = 23;

  // ==========================================================================
  // Command inputs and widths
  // ==========================================================================
  localparam int unsigned NUM_CMD = 5;
  localparam int unsigned CMD_DYN_INIT = 0;
  localparam int unsigned CMD_HOLD = 1;
  localparam int unsigned CMD_ZERO = 2;
  localparam int unsigned CMD_TRANSFER = 3;
  localparam int unsigned CMD_CALIB = 4;
  localparam int unsigned MEAS_W = 24;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [MEAS_W-1:0] MEAS_RST = 24'h000000;
  localparam logic [QUAL_CNT_W-1:0] CNT_RST = 23'h000000;

  // Qualifier states, Gray-coded along idle, counting, qualified.
  typedef enum logic [1:0] {
    RGCI_Q_IDLE = 2'b00,
    RGCI_Q_COUNT = 2'b01,
    RGCI_Q_HELD = 2'b11
  } rgci_qstate_t;

  // One-cycle command strobes issued on release.
  typedef struct packed {
    logic calib;
    logic transfer;
    logic zero;
    logic dyn_init;
  } rgci_cmd_t;

  // Relay contact drive for one tolerance limit.
  typedef struct packed {
    logic open_contact;
    logic closed_contact;
  } rgci_relay_t;

endpackage : rgci_pkg

// [design/rgci_qualifier.sv]
// One command input: synchroniser and minimum-width pulse qualifier.
`timescale 1ns/1ns
module rgci_qualifier #(
  // Must be at least two and fit the counter width.
  parameter int unsigned QUAL_CYCLES = rgci_pkg::QUAL_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_pin,
  output logic o_held,
  output logic o_release
);

  // ==========================================================================
  // Synchroniser
  // ==========================================================================
  logic sync1_reg;
  logic sync2_reg;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================================
  // Qualifier
  // ==========================================================================
  rgci_pkg::rgci_qstate_t state_reg;
  rgci_pkg::rgci_qstate_t state_next;
  logic [rgci_pkg::QUAL_CNT_W-1:0] cnt_reg;
  logic [rgci_pkg::QUAL_CNT_W-1:0] cnt_next;
  logic release_reg;
  logic release_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    release_next = 1'b0;
    case (state_reg)
      rgci_pkg::RGCI_Q_IDLE: begin
        cnt_next = rgci_pkg::CNT_RST;
        if (sync2_reg) begin
          state_next = rgci_pkg::RGCI_Q_COUNT;
          cnt_next = rgci_pkg::QUAL_CNT_W'(1);
        end
      end
      rgci_pkg::RGCI_Q_COUNT: begin
        // A pulse dropped before the full time is discarded.
        if (!sync2_reg) begin
          state_next = rgci_pkg::RGCI_Q_IDLE;
        end else if (cnt_reg ==
            rgci_pkg::QUAL_CNT_W'(QUAL_CYCLES - 1)) begin
          state_next = rgci_pkg::RGCI_Q_HELD;
        end else begin
          cnt_next = cnt_reg + rgci_pkg::QUAL_CNT_W'(1);
        end
      end
      rgci_pkg::RGCI_Q_HELD: begin
        if (!sync2_reg) begin
          state_next = rgci_pkg::RGCI_Q_IDLE;
          release_next = 1'b1;
        end
      end
      default: begin
        state_next = rgci_pkg::RGCI_Q_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= rgci_pkg::RGCI_Q_IDLE;
      cnt_reg <= rgci_pkg::CNT_RST;
      release_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      release_reg <= release_next;
    end
  end

  assign o_held = (state_reg == rgci_pkg::RGCI_Q_HELD);
  assign o_release = release_reg;

  a_release_after_held: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    release_reg |-> $past(state_reg) == rgci_pkg::RGCI_Q_HELD)
    else $error("Release without a qualified pulse.");

  a_short_pulse_drop: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (state_reg == rgci_pkg::RGCI_Q_COUNT && !sync2_reg) |=> 
    (state_reg == rgci_pkg::RGCI_Q_IDLE) ##1 !release_reg)
    else $error("Short pulse was not discarded.");

  a_held_after_count: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    $rose(state_reg == rgci_pkg::RGCI_Q_HELD) |->
    cnt_reg == rgci_pkg::QUAL_CNT_W'(QUAL_CYCLES - 1))
    else $error("Qualified before the full time.");

endmodule : rgci_qualifier

// [design/rgci_top.sv]
// Remote gage command inputs and tolerance relays, top level.
`timescale 1ns/1ns
module rgci_top #(
  // Full time by default; a bench may shorten it to keep runs brief.
  parameter int unsigned QUAL_CYCLES = rgci_pkg::QUAL_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_dynamic_init_pin,
  input wire logic i_hold_pin,
  input wire logic i_zero_pin,
  input wire logic i_transfer_pin,
  input wire logic i_calib_pin,
  input wire logic [rgci_pkg::MEAS_W-1:0] i_meas,
  input wire logic [rgci_pkg::MEAS_W-1:0] i_low_limit,
  input wire logic [rgci_pkg::MEAS_W-1:0] i_high_limit,
  output logic [rgci_pkg::MEAS_W-1:0] o_display,
  output logic [rgci_pkg::MEAS_W-1:0] o_dyn_min,
  output logic [rgci_pkg::MEAS_W-1:0] o_dyn_max,
  output logic [rgci_pkg::MEAS_W-1:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_calib_req,
  output logic o_hold_active,
  output rgci_pkg::rgci_relay_t o_low_relay,
  output rgci_pkg::rgci_relay_t o_high_relay
);

  // ==========================================================================
  // Input qualification
  // ==========================================================================
  logic [rgci_pkg::NUM_CMD-1:0] pins;
  logic [rgci_pkg::NUM_CMD-1:0] held;
  logic [rgci_pkg::NUM_CMD-1:0] rel;
  rgci_pkg::rgci_cmd_t cmd;

  // Each pin has one fixed function; nothing remaps them.
  assign pins = {i_calib_pin, i_transfer_pin, i_zero_pin, i_hold_pin,
                 i_dynamic_init_pin};

  for (genvar g = 0; g < rgci_pkg::NUM_CMD; g++) begin : g_q
    rgci_qualifier #(
      .QUAL_CYCLES(QUAL_CYCLES)
    ) u_q (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_pin(pins[g]),
      .o_held(held[g]),
      .o_release(rel[g])
    );
  end

  assign cmd.dyn_init = rel[rgci_pkg::CMD_DYN_INIT];
  assign cmd.zero = rel[rgci_pkg::CMD_ZERO];
  assign cmd.transfer = rel[rgci_pkg::CMD_TRANSFER];
  assign cmd.calib = rel[rgci_pkg::CMD_CALIB];

  // ==========================================================================
  // Measurement path
  // ==========================================================================
  function automatic logic signed [rgci_pkg::MEAS_W-1:0] to_s(
      input logic [rgci_pkg::MEAS_W-1:0] v);
    to_s = signed'(v);
  endfunction : to_s

  logic [rgci_pkg::MEAS_W-1:0] origin_reg, origin_next;
  logic [rgci_pkg::MEAS_W-1:0] disp_reg, disp_next;
  logic [rgci_pkg::MEAS_W-1:0] min_reg, min_next;
  logic [rgci_pkg::MEAS_W-1:0] max_reg, max_next;
  logic [rgci_pkg::MEAS_W-1:0] tx_reg, tx_next;
  logic tx_valid_reg, tx_valid_next;
  logic calib_reg, calib_next;
  logic hold_reg, hold_next;
  logic first_reg, first_next;
  logic [rgci_pkg::MEAS_W-1:0] dev;
  rgci_pkg::rgci_relay_t low_reg, low_next;
  rgci_pkg::rgci_relay_t high_reg, high_next;

  always_comb begin
    origin_next = origin_reg;
    disp_next = disp_reg;
    min_next = min_reg;
    max_next = max_reg;
    first_next = first_reg;
    dev = i_meas - origin_reg;
    hold_next = held[rgci_pkg::CMD_HOLD];
    // Zero takes the raw value so the display shows only the deviation.
    if (cmd.zero) begin
      origin_next = i_meas;
    end
    // Hold freezes the display and the dynamic extremes; a dynamic init still clears the extremes while held.
    if (!hold_reg) begin
      disp_next = dev;
      if (first_reg || to_s(dev) < to_s(min_reg)) begin
        min_next = dev;
      end
      if (first_reg || to_s(dev) > to_s(max_reg)) begin
        max_next = dev;
      end
      first_next = 1'b0;
    end
    if (cmd.dyn_init) begin
      min_next = rgci_pkg::MEAS_RST;
      max_next = rgci_pkg::MEAS_RST;
      first_next = 1'b1;
    end
    tx_valid_next = cmd.transfer;
    tx_next = cmd.transfer ? disp_reg : tx_reg;
    calib_next = cmd.calib;
    // Relay energised when outside the limit: in tolerance the open
    // contact stays open and the closed contact stays closed.
    low_next.open_contact = to_s(disp_reg) < to_s(i_low_limit);
    low_next.closed_contact = !low_next.open_contact;
    high_next.open_contact = to_s(disp_reg) > to_s(i_high_limit);
    high_next.closed_contact = !high_next.open_contact;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      origin_reg <= rgci_pkg::MEAS_RST;
      disp_reg <= rgci_pkg::MEAS_RST;
      min_reg <= rgci_pkg::MEAS_RST;
      max_reg <= rgci_pkg::MEAS_RST;
      tx_reg <= rgci_pkg::MEAS_RST;
      tx_valid_reg <= 1'b0;
      calib_reg <= 1'b0;
      hold_reg <= 1'b0;
      first_reg <= 1'b1;
      low_reg <= 2'b01;
      high_reg <= 2'b01;
    end else begin
      origin_reg <= origin_next;
      disp_reg <= disp_next;
      min_reg <= min_next;
      max_reg <= max_next;
      tx_reg <= tx_next;
      tx_valid_reg <= tx_valid_next;
      calib_reg <= calib_next;
      hold_reg <= hold_next;
      first_reg <= first_next;
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  assign o_display = disp_reg;
  assign o_dyn_min = min_reg;
  assign o_dyn_max = max_reg;
  assign o_tx_data = tx_reg;
  assign o_tx_valid = tx_valid_reg;
  assign o_calib_req = calib_reg;
  assign o_hold_active = hold_reg;
  assign o_low_relay = low_reg;
  assign o_high_relay = high_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_hold_freeze: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    hold_reg |=> $stable(disp_reg))
    else $error("Display changed while held.");

  a_zero_origin: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    cmd.zero |=> origin_reg == $past(i_meas))
    else $error("Zero did not capture origin.");

  a_tx_value: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    cmd.transfer |=> tx_valid_reg && tx_reg == $past(disp_reg))
    else $error("Transfer sent wrong value.");

  a_dyn_clear: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    cmd.dyn_init |=> first_reg && min_reg == rgci_pkg::MEAS_RST)
    else $error("Dynamic init did not clear.");

  a_calib_pulse: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    cmd.calib |=> calib_reg ##1 !calib_reg)
    else $error("Calibration request not one pulse.");

  a_relay_exclusive: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    low_reg.open_contact != low_reg.closed_contact &&
    high_reg.open_contact != high_reg.closed_contact)
    else $error("Relay contacts not complementary.");

  a_low_in_tol: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    !(to_s(disp_reg) < to_s(i_low_limit)) |=> !low_reg.open_contact)
    else $error("Lower relay wrong in tolerance.");

  a_high_out_tol: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (to_s(disp_reg) > to_s(i_high_limit)) |=> high_reg.open_contact)
    else $error("Upper relay not set above limit.");

  a_hold_follow: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    held[rgci_pkg::CMD_HOLD] |=> hold_reg)
    else $error("Qualified hold not shown.");

  a_display_track: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    !hold_reg |=> disp_reg == $past(dev))
    else $error("Display did not follow the measurement.");

  a_extreme_order: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    !first_reg |-> !(to_s(max_reg) < to_s(min_reg)))
    else $error("Dynamic extremes out of order.");

  a_tx_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    !cmd.transfer |=> $stable(tx_reg))
    else $error("Sent value changed without a transfer.");

endmodule : rgci_top

// [verification/rgci_plc_model.sv]
// Remote controller model that drives the five command pins.
`timescale 1ns/1ns
module rgci_plc_model (
  input wire logic i_core_clk,
  output logic [4:0] o_pins
);
  initial begin
    o_pins = 5'h00;
  end

  // ==========================================================================
  // Pulse driver
  // ==========================================================================
  // Pins change 1 ns after an edge, so the block never samples them mid-edge.
  // A pin is released only after n whole cycles high.
  task automatic pulse(input int idx, input int n);
    @(posedge i_core_clk);
    #1 o_pins[idx] = 1'b1;
    repeat (n) @(posedge i_core_clk);
    #1 o_pins[idx] = 1'b0;
  endtask : pulse
endmodule : rgci_plc_model

// [verification/tb_top.sv]
// Self-checking testbench for the remote gage command input block.
`timescale 1ns/1ns
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [4:0] pins;
  logic [rgci_pkg::MEAS_W-1:0] meas = 24'h000000;
  logic [rgci_pkg::MEAS_W-1:0] low_lim = 24'hFFFFE0;
  logic [rgci_pkg::MEAS_W-1:0] high_lim = 24'h000020;
  logic [rgci_pkg::MEAS_W-1:0] display;
  logic [rgci_pkg::MEAS_W-1:0] tx_data;
  logic tx_valid;
  logic calib_req;
  logic hold_active;
  rgci_pkg::rgci_relay_t low_relay;
  rgci_pkg::rgci_relay_t high_relay;
  logic [rgci_pkg::MEAS_W-1:0] dyn_min;
  logic [rgci_pkg::MEAS_W-1:0] dyn_max;
  // The full 50 ms would need 5,000,000 cycles; a short stand-in keeps the
  // run brief while every qualified command is still exercised.
  localparam int unsigned TB_QUAL = 200;
  int mismatches = 0;
  int comparisons = 0;

  always #5 i_core_clk = ~i_core_clk;

  rgci_plc_model plc (
    .i_core_clk(i_core_clk),
    .o_pins(pins)
  );

  rgci_top #(
    .QUAL_CYCLES(TB_QUAL)
  ) dut (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_dynamic_init_pin(pins[rgci_pkg::CMD_DYN_INIT]),
    .i_hold_pin(pins[rgci_pkg::CMD_HOLD]),
    .i_zero_pin(pins[rgci_pkg::CMD_ZERO]),
    .i_transfer_pin(pins[rgci_pkg::CMD_TRANSFER]),
    .i_calib_pin(pins[rgci_pkg::CMD_CALIB]),
    .i_meas(meas),
    .i_low_limit(low_lim),
    .i_high_limit(high_lim),
    .o_display(display),
    .o_dyn_min(dyn_min),
    .o_dyn_max(dyn_max),
    .o_tx_data(tx_data),
    .o_tx_valid(tx_valid),
    .o_calib_req(calib_req),
    .o_hold_active(hold_active),
    .o_low_relay(low_relay),
    .o_high_relay(high_relay)
  );

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic settle;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask : settle

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    check("tx_valid", {23'h0, tx_valid}, 24'h0);
    check("calib_req", {23'h0, calib_req}, 24'h0);
    check("hold_active", {23'h0, hold_active}, 24'h0);
    check("tx_data", tx_data, 24'h000000);
    check("low_relay", {22'h0, low_relay}, 24'h000001);
    check("high_relay", {22'h0, high_relay}, 24'h000001);
  endtask : t_reset

  // Limits are signed, so the negative rows catch an unsigned compare.
  task automatic t_relays;
    logic [23:0] m [0:5] = '{24'h000000, 24'hFFFFE0, 24'hFFFFDF,
                             24'h000020, 24'h000021, 24'h800000};
    logic [1:0] lo [0:5] = '{2'b01, 2'b01, 2'b10, 2'b01, 2'b01, 2'b10};
    logic [1:0] hi [0:5] = '{2'b01, 2'b01, 2'b01, 2'b01, 2'b10, 2'b01};
    for (int k = 0; k < 6; k++) begin
      meas = m[k];
      settle();
      check("display", display, m[k]);
      check("low_relay", {22'h0, low_relay}, {22'h0, lo[k]});
      check("high_relay", {22'h0, high_relay}, {22'h0, hi[k]});
    end
  endtask : t_relays

  // A pulse one cycle short of qualifying must leave no trace.
  task automatic t_short_pulses;
    for (int k = 0; k < rgci_pkg::NUM_CMD; k++) begin
      meas = 24'h000005;
      fork
        plc.pulse(k, TB_QUAL - 1);
        begin
          repeat (50) @(posedge i_core_clk);
          #1 meas = 24'h000007 + k;
          settle();
          check("display", display, 24'h000007 + k);
        end
      join
      for (int c = 0; c < 20; c++) begin
        @(posedge i_core_clk);
        #1;
        check("tx_valid", {23'h0, tx_valid}, 24'h0);
        check("calib_req", {23'h0, calib_req}, 24'h0);
        check("hold_active", {23'h0, hold_active}, 24'h0);
      end
      check("display", display, 24'h000007 + k);
      check("tx_data", tx_data, 24'h000000);
    end
  endtask : t_short_pulses

  // Transfer fires four cycles after the pin falls, never while it is high.
  task automatic t_transfer;
    int n;
    meas = 24'h000011;
    settle();
    plc.pulse(rgci_pkg::CMD_TRANSFER, TB_QUAL);
    for (n = 1; n <= 8; n++) begin
      @(posedge i_core_clk);
      #1;
      if (tx_valid) break;
    end
    check("tx_delay", n[23:0], 24'h000004);
    check("tx_data", tx_data, 24'h000011);
    @(posedge i_core_clk);
    #1;
    check("tx_valid", {23'h0, tx_valid}, 24'h0);
  endtask : t_transfer

  task automatic t_calib;
    int n;
    plc.pulse(rgci_pkg::CMD_CALIB, TB_QUAL);
    for (n = 1; n <= 8; n++) begin
      @(posedge i_core_clk);
      #1;
      if (calib_req) break;
    end
    check("calib_delay", n[23:0], 24'h000004);
    @(posedge i_core_clk);
    #1;
    check("calib_req", {23'h0, calib_req}, 24'h0);
  endtask : t_calib

  // Hold freezes the display only once qualified, and lets go on the fall.
  task automatic t_hold;
    int n;
    meas = 24'h000012;
    settle();
    check("display", display, 24'h000012);
    fork
      plc.pulse(rgci_pkg::CMD_HOLD, TB_QUAL + 20);
      begin
        for (n = 1; n <= TB_QUAL + 8; n++) begin
          @(posedge i_core_clk);
          #1;
          if (hold_active) break;
        end
        check("hold_delay", n[23:0], 24'(TB_QUAL + 4));
        meas = 24'h000019;
        settle();
        check("display", display, 24'h000012);
        check("hold_active", {23'h0, hold_active}, 24'h000001);
      end
    join
    repeat (2) settle();
    check("hold_active", {23'h0, hold_active}, 24'h0);
    check("display", display, 24'h000019);
  endtask : t_hold

  // The part is placed first, then the extremes are cleared and re-seeded.
  task automatic t_dyn_init;
    meas = 24'h000008;
    settle();
    plc.pulse(rgci_pkg::CMD_DYN_INIT, TB_QUAL);
    repeat (2) settle();
    check("dyn_min", dyn_min, 24'h000008);
    check("dyn_max", dyn_max, 24'h000008);
    meas = 24'h00000C;
    settle();
    meas = 24'h000004;
    settle();
    check("dyn_max", dyn_max, 24'h00000C);
    check("dyn_min", dyn_min, 24'h000004);
  endtask : t_dyn_init

  task automatic t_zero;
    meas = 24'h000030;
    settle();
    check("display", display, 24'h000030);
    plc.pulse(rgci_pkg::CMD_ZERO, TB_QUAL);
    repeat (2) settle();
    check("display", display, 24'h000000);
    meas = 24'h000035;
    settle();
    check("display", display, 24'h000005);
    check("high_relay", {22'h0, high_relay}, 24'h000001);
  endtask : t_zero

  initial begin
    repeat (4) @(posedge i_core_clk);
    #1;
    t_reset();
    i_nrst = 1'b1;
    t_relays();
    t_short_pulses();
    t_transfer();
    t_calib();
    t_hold();
    t_dyn_init();
    t_zero();
    test_done();
  end
endmodule : tb_top
